//--- hw/mapai_defines.svh
// Purpose: Constants for the memory access port address sequencer
// Assumes: One clock, no register bus, plain control ports
// Notes:   Increment mode, size and reset address constants follow
`ifndef MAPAI_DEFINES_SVH
`define MAPAI_DEFINES_SVH

`define MAPAI_INC_OFF    2'h0
`define MAPAI_INC_SINGLE 2'h1
`define MAPAI_INC_PACKED 2'h2
`define MAPAI_SIZE_BYTE  3'h0
`define MAPAI_SIZE_HALF  3'h1
`define MAPAI_SIZE_WORD  3'h2
`define MAPAI_INC_BITS   10
`define MAPAI_RESET_ADDR 32'h0000_0000

`endif

//--- hw/mapai_pkg.sv
// Purpose: Types for the memory access port address sequencer
// Assumes: Constants come from mapai_defines.svh
// Notes:   Request and downstream bus command travel as packed structs
package mapai_pkg;

	typedef struct packed {
		logic        write;
		logic        banked;
		logic [1:0]  bank;
		logic [31:0] wdata;
	} mapai_req_type;

	typedef struct packed {
		logic [31:0] addr;
		logic [3:0]  strb;
		logic        write;
		logic [31:0] wdata;
	} mapai_bus_type;

	typedef enum logic [2:0] {
		MAPAI_IDLE  = 3'b001,
		MAPAI_ISSUE = 3'b010,
		MAPAI_WAIT  = 3'b100
	} mapai_state_type;

endpackage : mapai_pkg

//--- hw/mapai_port.sv
// Purpose: Transfer address sequencing and stall handling of the port
// Assumes: Debug port and memory bus share sys_clk_in
// Notes:   Sub-word sizes and packing are always built in
`include "mapai_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module mapai_port (
	input  wire logic                   sys_clk_in,
	input  wire logic                   reset_n_in,
	input  wire logic                   cfg_write_in,
	input  wire logic [1:0]             cfg_addr_inc_in,
	input  wire logic [2:0]             cfg_size_in,
	input  wire logic                   tar_write_in,
	input  wire logic [31:0]            tar_wdata_in,
	input  wire logic                   req_valid_in,
	input  wire mapai_pkg::mapai_req_type req_in,
	input  wire logic                   abort_in,
	output logic                        ready_out,
	output logic                        done_out,
	output logic                        error_out,
	output logic [31:0]                 rdata_out,
	output logic [1:0]                  addr_inc_out,
	output logic [2:0]                  size_out,
	output logic [31:0]                 transfer_address_reg_out,
	output logic                        bus_valid_out,
	output mapai_pkg::mapai_bus_type    bus_out,
	input  wire logic                   bus_done_in,
	input  wire logic                   bus_error_in,
	input  wire logic [31:0]            bus_rdata_in
);

	mapai_pkg::mapai_state_type state;
	mapai_pkg::mapai_state_type next_state;
	logic [31:0] transfer_address_reg;
	logic [31:0] next_transfer_address_reg;
	logic [1:0]  addr_inc;
	logic [1:0]  next_addr_inc;
	logic [2:0]  size;
	logic [2:0]  next_size;
	logic [31:0] data_rw_reg;
	logic [31:0] next_data_rw_reg;
	mapai_pkg::mapai_req_type cur;
	mapai_pkg::mapai_req_type next_cur;
	logic [1:0]  beats;
	logic [1:0]  next_beats;
	logic        done;
	logic        next_done;
	logic        error;
	logic        next_error;
	logic [9:0]  step;
	logic [1:0]  lane;
	logic [31:0] addr;
	logic [3:0]  strb;
	logic        packed_mode;
	logic        last_beat;
	logic        take;
	logic        in_wait;
	logic        beat_err;
	logic        beat_ok;
	logic        finish;
	logic        inc_on;
	logic [31:0] lane_mask;

	assign packed_mode = (addr_inc == `MAPAI_INC_PACKED);
	assign lane        = transfer_address_reg[1:0];

	always_comb begin
		unique case (size)
			`MAPAI_SIZE_BYTE: step = 10'h001;
			`MAPAI_SIZE_HALF: step = 10'h002;
			default:          step = 10'h004;
		endcase
	end

	// Packing finishes after a fixed beat count: four byte beats or two halfword beats
	always_comb begin
		if (!packed_mode || size == `MAPAI_SIZE_WORD) begin
			last_beat = 1'b1;
		end else if (size == `MAPAI_SIZE_BYTE) begin
			last_beat = (beats == 2'h3);
		end else begin
			last_beat = (beats == 2'h1);
		end
	end

	// Banked accesses ignore the low nibble of the transfer address
	always_comb begin
		if (cur.banked) begin
			addr = {transfer_address_reg[31:4], cur.bank, 2'h0};
			strb = 4'hf;
		end else begin
			addr = transfer_address_reg;
			unique case (size)
				`MAPAI_SIZE_BYTE: strb = 4'h1 << lane;
				`MAPAI_SIZE_HALF: strb = lane[1] ? 4'hc : 4'h3;
				default:          strb = 4'hf;
			endcase
		end
	end

	always_comb begin
		bus_valid_out = (state == mapai_pkg::MAPAI_ISSUE);
		bus_out.addr  = addr;
		bus_out.strb  = strb;
		bus_out.write = cur.write;
		bus_out.wdata = cur.wdata;
	end

	// Abort wins over a bus answer landing in the same cycle
	always_comb begin
		take      = (state == mapai_pkg::MAPAI_IDLE)
		            && req_valid_in;
		in_wait   = (state == mapai_pkg::MAPAI_WAIT);
		beat_err  = in_wait
		            && (abort_in
		                || (bus_done_in && bus_error_in));
		beat_ok   = in_wait && !abort_in
		            && bus_done_in && !bus_error_in;
		finish    = beat_ok && (last_beat || cur.banked);
		inc_on    = !cur.banked
		            && (addr_inc != `MAPAI_INC_OFF);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}},
		             {8{strb[1]}}, {8{strb[0]}}};
	end

	// Config is frozen while busy so a transfer never changes mode midway
	always_comb begin
		next_addr_inc = addr_inc;
		next_size     = size;
		if (state == mapai_pkg::MAPAI_IDLE && cfg_write_in) begin
			// Reserved 0b11 is stored as off so readback shows the real mode
			next_addr_inc = (cfg_addr_inc_in == 2'h3) ? `MAPAI_INC_OFF
			                : cfg_addr_inc_in;
			next_size = (cfg_size_in > `MAPAI_SIZE_WORD) ? `MAPAI_SIZE_WORD
			            : cfg_size_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			addr_inc <= `MAPAI_INC_OFF;
			size     <= `MAPAI_SIZE_WORD;
		end else begin
			addr_inc <= next_addr_inc;
			size     <= next_size;
		end
	end

	always_comb begin
		next_transfer_address_reg = transfer_address_reg;
		if (state == mapai_pkg::MAPAI_IDLE && tar_write_in) begin
			next_transfer_address_reg = tar_wdata_in;
		end else if (beat_ok && inc_on) begin
			// Carry stops at bit 10; upper bits are kept
			next_transfer_address_reg = {transfer_address_reg[31:10],
			    transfer_address_reg[9:0] + step};
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			transfer_address_reg <= `MAPAI_RESET_ADDR;
		end else begin
			transfer_address_reg <= next_transfer_address_reg;
		end
	end

	always_comb begin
		next_data_rw_reg = data_rw_reg;
		if (beat_ok && !cur.write) begin
			if (cur.banked || size == `MAPAI_SIZE_WORD) begin
				next_data_rw_reg = bus_rdata_in;
			end else begin
				// Merge keeps lanes gathered by earlier beats of a pack
				next_data_rw_reg = (bus_rdata_in & lane_mask)
				                   | (data_rw_reg & ~lane_mask);
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			data_rw_reg <= 32'h0000_0000;
		end else begin
			data_rw_reg <= next_data_rw_reg;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			mapai_pkg::MAPAI_IDLE: begin
				if (take) begin
					next_state = mapai_pkg::MAPAI_ISSUE;
				end
			end
			mapai_pkg::MAPAI_ISSUE: begin
				next_state = mapai_pkg::MAPAI_WAIT;
			end
			mapai_pkg::MAPAI_WAIT: begin
				// No timeout: a slow target holds the port busy until it answers or abort_in is raised
				if (beat_err || finish) begin
					next_state = mapai_pkg::MAPAI_IDLE;
				end else if (beat_ok) begin
					next_state = mapai_pkg::MAPAI_ISSUE;
				end
			end
			default: next_state = mapai_pkg::MAPAI_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= mapai_pkg::MAPAI_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// The request is latched at the take so the caller may change it after
	always_comb begin
		next_cur = cur;
		if (take) begin
			next_cur = req_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	always_comb begin
		next_beats = beats;
		if (take) begin
			next_beats = 2'h0;
		end else if (beat_ok && !finish) begin
			next_beats = beats + 2'h1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			beats <= 2'h0;
		end else begin
			beats <= next_beats;
		end
	end

	always_comb begin
		next_done  = beat_err || finish;
		next_error = beat_err;
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			done  <= 1'b0;
			error <= 1'b0;
		end else begin
			done  <= next_done;
			error <= next_error;
		end
	end

	// Ready is what the debug port samples at capture to choose OK or WAIT
	assign ready_out                = (state == mapai_pkg::MAPAI_IDLE);
	assign done_out                 = done;
	assign error_out                = error;
	assign rdata_out                = data_rw_reg;
	assign addr_inc_out             = addr_inc;
	assign size_out                 = size;
	assign transfer_address_reg_out = transfer_address_reg;

endmodule : mapai_port

`default_nettype wire

//--- verif/mapai_port_chk.sv
// Purpose: Port checks for mapai_port
// Assumes: One clock, async active-low reset
// Notes:   Bound to every mapai_port instance
`timescale 1ns/1ps
`default_nettype none
module mapai_chk (
	input wire logic                     sys_clk_in,
	input wire logic                     reset_n_in,
	input wire logic                     cfg_write_in,
	input wire logic [1:0]               cfg_addr_inc_in,
	input wire logic [2:0]               cfg_size_in,
	input wire logic                     tar_write_in,
	input wire logic                     req_valid_in,
	input wire mapai_pkg::mapai_req_type req_in,
	input wire logic                     abort_in,
	input wire logic                     ready_out,
	input wire logic                     done_out,
	input wire logic                     error_out,
	input wire logic [1:0]               addr_inc_out,
	input wire logic [2:0]               size_out,
	input wire logic [31:0]              transfer_address_reg_out,
	input wire logic                     bus_valid_out,
	input wire mapai_pkg::mapai_bus_type bus_out,
	input wire logic                     bus_done_in,
	input wire logic                     bus_error_in
);
	logic bk;
	logic next_bk;
	logic beat;
	// Banked flag is only known at the take, so it is kept here
	always_comb next_bk = (req_valid_in && ready_out) ? req_in.banked : bk;
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
		if (!reset_n_in) bk <= 1'b0;
		else bk <= next_bk;
	assign beat = !ready_out && !bus_valid_out && bus_done_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	AST_ADDR: assert property (bus_valid_out && !bk |->
		bus_out.addr == transfer_address_reg_out) else $error("bad bus address");
	AST_STEP: assert property (beat && !bus_error_in && !abort_in && !bk
		&& addr_inc_out != 2'h0 |=> transfer_address_reg_out[9:0] ==
		$past(transfer_address_reg_out[9:0]) + (10'h1 << $past(size_out))
		&& $stable(transfer_address_reg_out[31:10])) else $error("bad step");
	AST_ERR: assert property (beat && bus_error_in |=> done_out && error_out
		&& $stable(transfer_address_reg_out)) else $error("error not kept");
	AST_ABORT: assert property (!ready_out && !bus_valid_out && abort_in
		&& !bus_done_in |=> $stable(transfer_address_reg_out) ##[0:2]
		(done_out && error_out)) else $error("abort not kept");
	AST_BANK: assert property (bk && !ready_out
		|=> $stable(transfer_address_reg_out)) else $error("banked moved addr");
	AST_OFF: assert property (addr_inc_out == 2'h0 && !tar_write_in
		|=> $stable(transfer_address_reg_out)) else $error("addr moved in off");
	AST_TAKE: assert property (req_valid_in && ready_out
		|=> bus_valid_out && !ready_out) else $error("request not taken");
	AST_STALL: assert property (!ready_out && !bus_done_in && !abort_in
		|=> !done_out) else $error("done without bus done");
	AST_READY: assert property (done_out |-> ready_out)
		else $error("not ready after done");
	AST_CFG: assert property (cfg_write_in && ready_out |=> addr_inc_out ==
		($past(cfg_addr_inc_in) == 2'h3 ? 2'h0 : $past(cfg_addr_inc_in)) &&
		size_out == ($past(cfg_size_in) > 3'h2 ? 3'h2 : $past(cfg_size_in)))
		else $error("bad config readback");
	AST_LANE: assert property (bus_valid_out && !bk && size_out == 3'h1
		|-> bus_out.strb == (bus_out.addr[1] ? 4'hc : 4'h3))
		else $error("bad halfword lanes");
	cover property (done_out && error_out);
	cover property (beat && addr_inc_out == 2'h2);
	cover property (bus_valid_out && bk);
endmodule : mapai_chk
bind mapai_port mapai_chk u_chk (.*);
`default_nettype wire

//--- verif/mapai_mem.sv
// Purpose: Memory target model on the downstream bus
// Assumes: One transfer at a time
// Notes:   Stall length and error set by the bench
`timescale 1ns/1ps
`default_nettype none
module mapai_mem (
	input wire logic                     clk_in,
	input wire logic                     rst_n_in,
	input wire logic                     valid_in,
	input wire mapai_pkg::mapai_bus_type bus_in,
	input wire logic [7:0]               dly_in,
	input wire logic                     err_in,
	output logic                         done_out,
	output logic                         error_out,
	output logic [31:0]                  rdata_out
);
	logic       busy;
	logic [7:0] cnt;
	logic [31:0] pat;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy <= 1'b0;
			cnt <= 8'h00;
		end else if (valid_in) begin // Stall length of 0 to 255 cycles
			busy <= 1'b1;
			cnt <= dly_in;
		end else if (busy && cnt != 8'h00)
			cnt <= cnt - 8'h01;
		else
			busy <= 1'b0;
	end
	assign done_out = busy && cnt == 8'h00;
	assign error_out = done_out && err_in;
	assign pat = 32'ha5a5a5a5 ^ {4{bus_in.addr[7:0]}};
	// Inverted outside done, so stale lanes cannot pass a merge
	assign rdata_out = done_out ? pat : ~pat;
endmodule : mapai_mem
`default_nettype wire

//--- verif/mapai_port_bench.sv
// Purpose: Self-checking bench for mapai_port
// Assumes: 200 MHz clock, inputs driven 1 ns after the edge
// Notes:   Abort case runs last as the model keeps counting
`timescale 1ns/1ps
`default_nettype none
module mapai_port_bench;
	logic sys_clk_in = 0, reset_n_in = 0, cfg_write_in = 0, tar_write_in = 0;
	logic req_valid_in = 0, abort_in = 0, err = 0;
	logic [1:0] cfg_addr_inc_in = 0, addr_inc_out;
	logic [2:0] cfg_size_in = 0, size_out;
	logic [7:0] dly = 0;
	logic [31:0] tar_wdata_in = 0, rdata_out, transfer_address_reg_out;
	logic [31:0] bus_rdata_in, la;
	logic ready_out, done_out, error_out, bus_valid_out, bus_done_in;
	logic bus_error_in;
	mapai_pkg::mapai_req_type req_in = '0;
	mapai_pkg::mapai_bus_type bus_out;
	int fails = 0, total_checks = 0, beats = 0, s;
	mapai_port u_dut (.*);
	mapai_mem u_mem (.clk_in(sys_clk_in), .rst_n_in(reset_n_in),
		.valid_in(bus_valid_out), .bus_in(bus_out), .dly_in(dly),
		.err_in(err), .done_out(bus_done_in), .error_out(bus_error_in),
		.rdata_out(bus_rdata_in));
	always #2.5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) if (bus_valid_out === 1'b1) begin
		beats++;
		la = bus_out.addr;
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic tick;
		@(posedge sys_clk_in);
		#1;
	endtask : tick
	task automatic setup(logic [1:0] m, logic [2:0] z, logic [31:0] a);
		{cfg_addr_inc_in, cfg_size_in, tar_wdata_in} = {m, z, a};
		{cfg_write_in, tar_write_in} = 2'h3;
		tick;
		{cfg_write_in, tar_write_in} = 2'h0;
		beats = 0;
	endtask : setup
	task automatic xfer(logic w, b, logic [1:0] k, logic [7:0] d, logic a);
		int i;
		dly = d;
		req_in = '{w, b, k, 32'h1234_5678};
		req_valid_in = 1;
		tick;
		req_valid_in = 0;
		for (i = 0; i < 300 && done_out !== 1'b1; i++) begin
			if (i == 3) abort_in = a;
			req_valid_in = (i == 5 && d > 8); // Refused while busy
			tick;
		end
		abort_in = 0;
		if (i == 300) begin
			fails++;
			wrap_up;
		end
	endtask : xfer
	task automatic wrap_up;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (8) @(posedge sys_clk_in);
		#1 reset_n_in = 1;
		chk("size", 32'h2, size_out);
		chk("inc", 32'h0, addr_inc_out);
		setup(2'h2, 3'h1, 32'h0);
		chk("inc", 32'h2, addr_inc_out);
		xfer(1, 0, 0, 0, 0);
		chk("beats", 32'h2, beats);
		chk("tar", 32'h4, transfer_address_reg_out);
		setup(2'h2, 3'h0, 32'h10);
		xfer(0, 0, 0, 2, 0);
		chk("beats", 32'h4, beats);
		chk("tar", 32'h14, transfer_address_reg_out);
		chk("rdata", 32'hb6b7b4b5, rdata_out);
		for (s = 0; s < 3; s++) begin
			setup(2'h1, s[2:0], 32'h17fc);
			xfer(0, 0, 0, 1, 0);
			chk("tar", {22'h5, 10'h3fc + (10'h1 << s)},
				transfer_address_reg_out);
		end
		for (s = 0; s < 4; s += 3) begin
			setup(s[1:0], 3'h2, 32'h40);
			xfer(1, 0, 0, 0, 0);
			chk("tar", 32'h40, transfer_address_reg_out);
		end
		setup(2'h1, 3'h2, 32'h1234);
		xfer(0, 1, 2'h2, 0, 0);
		chk("bank addr", 32'h1238, la);
		chk("tar", 32'h1234, transfer_address_reg_out);
		setup(2'h1, 3'h2, 32'h80);
		xfer(1, 0, 0, 40, 0);
		chk("beats", 32'h1, beats);
		chk("tar", 32'h84, transfer_address_reg_out);
		xfer(1, 0, 0, 0, 0); // Retry after the stall
		chk("tar", 32'h88, transfer_address_reg_out);
		err = 1;
		setup(2'h2, 3'h1, 32'h20);
		xfer(1, 0, 0, 0, 0);
		chk("error", 32'h1, error_out);
		chk("beats", 32'h1, beats);
		chk("tar", 32'h20, transfer_address_reg_out);
		err = 0;
		setup(2'h1, 3'h2, 32'h30);
		xfer(0, 0, 0, 50, 1);
		chk("error", 32'h1, error_out);
		chk("tar", 32'h30, transfer_address_reg_out);
		wrap_up;
	end
endmodule : mapai_port_bench
`default_nettype wire
